// [inc/ahl_cfg.svh]
// Constants of the point-to-point ASCII host-link command interpreter.
`ifndef AHL_CFG_SVH
`define AHL_CFG_SVH
`define AHL_CLK_HZ 200000000
`define AHL_BAUD 38400
`define AHL_BIT_CYC (`AHL_CLK_HZ / `AHL_BAUD)
`define AHL_CH_ENQ 8'h05
`define AHL_CH_STAR 8'h2a
`define AHL_CH_CR 8'h0d
`define AHL_ERR_H0 8'h45
`define AHL_ERR_H1 8'h52
`define AHL_FRAME_MAX 6'h20
`define AHL_CHANNELS 8'h10
`endif

// [inc/ahl_pkg.sv]
// Types of the point-to-point ASCII host-link command interpreter.
package ahl_pkg;
	typedef enum logic [2:0] {
		AHL_IDLE = 3'b000,
		AHL_ECHO = 3'b001,
		AHL_RECV = 3'b010,
		AHL_EXEC = 3'b011,
		AHL_SEND = 3'b100
	} ahl_state_e;
	typedef logic [7:0] ahl_byte_t;
endpackage

// [tb/ahl_host_model.sv]
// Host computer model on the far side of the serial link.
`timescale 1ns/1ps
`default_nettype none
module ahl_host_model #(
	parameter int BIT_CYC = 16
) (
	input wire logic sys_clk,
	input wire logic lineIn,
	output logic lineOut
);
	initial lineOut = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// 8N1 character format.
	// No controller identifier sent.
	// Gap adds idle cycles before the byte to play a slow host.
	task automatic sendByte(input logic [7:0] b, input int gap);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		repeat (gap) @(posedge sys_clk);
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			#1;
			lineOut = fr[i];
			repeat (BIT_CYC - 1) @(posedge sys_clk);
		end
	endtask

	// Framing checked at stop.
	// Returns unknown on timeout or a bad stop bit; ends at the stop sample.
	task automatic recvByte(output logic [7:0] b);
		int n;
		b = 'x;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (lineIn !== 1'b0 && n < 200 * BIT_CYC);
		if (lineIn !== 1'b0)
			return;
		repeat (BIT_CYC / 2) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CYC) @(posedge sys_clk);
			#1;
			if (i < 8)
				b[i] = lineIn;
			else if (lineIn !== 1'b1)
				b = 'x;
		end
	endtask
endmodule
`default_nettype wire

// [tb/ascii_host_link_p2p_slave_tb_top.sv]
// Self-checking testbench of the point-to-point host-link slave.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failures++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module ascii_host_link_p2p_slave_tb_top;
	import ahl_pkg::*;
	localparam int BC = 16;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic serialRx;
	logic serialTx;
	logic serialTxEn;
	logic [15:0] inputBits = 16'h0000;
	logic [15:0] outputBits;
	logic sessionBusy;
	logic txLine;
	int failures = 0;
	int numChecks = 0;

	// The biased RS485 pair reads high while the device releases it.
	assign txLine = serialTxEn ? serialTx : 1'b1;

	ahl_slave #(.BIT_CYC(BC)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
		.serialRx(serialRx), .serialTx(serialTx), .serialTxEn(serialTxEn),
		.inputBits(inputBits), .outputBits(outputBits),
		.sessionBusy(sessionBusy));
	ahl_host_model #(.BIT_CYC(BC)) host_u (.sys_clk(sys_clk),
		.lineIn(txLine), .lineOut(serialRx));

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic sendStr(input string s, input int gap);
		for (int i = 0; i < s.len(); i++)
			host_u.sendByte(s[i], gap);
		host_u.sendByte(8'h2a, gap);
		host_u.sendByte(8'h0d, gap);
	endtask

	task automatic expectStr(input string s);
		logic [7:0] b;
		for (int i = 0; i < s.len() + 2; i++) begin
			host_u.recvByte(b);
			`CHK("reply byte", (i < s.len()) ? 8'(s[i]) : ((i == s.len()) ? 8'h2a : 8'h0d), b)
		end
	endtask

	task automatic session(input string cmd, input string rsp, input int gap);
		logic [7:0] e;
		fork
			host_u.sendByte(8'h05, 0);
			host_u.recvByte(e);
		join
		`CHK("echo", 8'h05, e)
		repeat (BC / 2 + 2) @(posedge sys_clk);
		#1;
		`CHK("busy in session", 1'b1, sessionBusy)
		fork
			sendStr(cmd, gap);
			expectStr(rsp);
		join
		repeat (BC / 2 + 4) @(posedge sys_clk);
		#1;
		`CHK("busy after reply", 1'b0, sessionBusy)
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic testReset();
		`CHK("tx idle", 1'b1, txLine)
		`CHK("tx enable", 1'b0, serialTxEn)
		`CHK("outputs", 16'h0000, outputBits)
		`CHK("busy", 1'b0, sessionBusy)
	endtask

	task automatic testIdleDiscard();
		host_u.sendByte(8'h52, 0);
		repeat (30 * BC) @(posedge sys_clk);
		#1;
		`CHK("idle busy", 1'b0, sessionBusy)
		`CHK("idle driver", 1'b0, serialTxEn)
	endtask

	task automatic testReadInput();
		@(posedge sys_clk);
		#1;
		inputBits = 16'ha5c3;
		session("RI", "RIA5C3", 0);
		inputBits = 16'h003c;
		session("RI", "RI003C", 0);
	endtask

	task automatic testWrite();
		session("WO0f01", "WO", BC);
		`CHK("out ch15", 16'h8000, outputBits)
		session("WO0301", "WO", 0);
		session("RO", "RO8008", 0);
	endtask

	task automatic testOverlong();
		logic [7:0] e;
		fork
			host_u.sendByte(8'h05, 0);
			host_u.recvByte(e);
		join
		`CHK("long echo", 8'h05, e)
		repeat (BC / 2 + 2) @(posedge sys_clk);
		for (int i = 0; i < 32; i++)
			host_u.sendByte(8'h31, 0);
		#1;
		`CHK("long busy at limit", 1'b1, sessionBusy)
		host_u.sendByte(8'h31, 0);
		repeat (BC) @(posedge sys_clk);
		#1;
		`CHK("long busy", 1'b0, sessionBusy)
		`CHK("long driver", 1'b0, serialTxEn)
	endtask

	task automatic testErrors();
		session("WO1001", "ER", 0);
		session("WO0g01", "ER", 0);
		session("XX", "ER", 0);
		session("WO0f", "ER", 0);
		`CHK("out kept", 16'h8008, outputBits)
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		#1;
		testReset();
		nrst = 1'b1;
		repeat (2) @(posedge sys_clk);
		testIdleDiscard();
		testReadInput();
		testWrite();
		testOverlong();
		testErrors();
		print_verdict();
	end

	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		$display("[ERR] watchdog expired");
		print_verdict();
	end
endmodule
`default_nettype wire

// [verilog/ahl_slave.sv]
// Point-to-point ASCII host-link slave on the primary serial port.
// Function
// RULE1 - Link defaults to 38400 baud, 8 data, 1 stop, no parity.
// RULE2 - Host opens a session with byte 0x05.
// RULE3 - Device echoes 0x05 when ready; host waits for it.
// RULE4 - Host then sends its whole command frame and awaits response.
// RULE5 - Frame: two-character header, ASCII data, then asterisk and CR.
// RULE6 - Binary bytes travel as two hex characters, 00 to FF.
// RULE7 - Accepted command is answered with same header, data, terminator.
// RULE8 - Sending the response ends the session; wait for new 0x05.
// RULE9 - Unknown header or illegal channel gives an error response.
// RULE10 - Responses are generated automatically, without user logic.
// RULE11 - Only one controller attached; frames carry no identifier.
// RULE12 - Idle discards non-0x05 bytes; error header differs from commands.
`timescale 1ns/1ps
`default_nettype none
`include "ahl_cfg.svh"
module ahl_slave import ahl_pkg::*; #(
	parameter int BIT_CYC = `AHL_BIT_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic serialRx,
	output logic serialTx,
	output logic serialTxEn,
	input wire logic [15:0] inputBits,
	output logic [15:0] outputBits,
	output logic sessionBusy
);
	if (BIT_CYC < 4) begin : gen_bad_bit_cyc
		$error("ahl_slave: bit period too short");
	end
	function automatic logic [4:0] hexVal(input ahl_byte_t c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hexVal = {1'b0, 4'(c - 8'h30)};
		end else if (c >= 8'h41 && c <= 8'h46) begin
			hexVal = {1'b0, 4'(c - 8'h37)};
		end else if (c >= 8'h61 && c <= 8'h66) begin
			hexVal = {1'b0, 4'(c - 8'h57)};
		end else begin
			hexVal = 5'h10;
		end
	endfunction
	function automatic ahl_byte_t hexChar(input logic [3:0] n);
		hexChar = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction
	ahl_state_e state;
	logic rxValid;
	ahl_byte_t rxData;
	logic txValid;
	ahl_byte_t txData;
	logic txReady;
	ahl_byte_t hdr0, hdr1;
	logic [15:0] dataAcc;
	logic [4:0] nibCnt;
	logic badData;
	logic sawStar;
	logic [5:0] frameLen;
	ahl_byte_t resp [0:7];
	logic [3:0] respLen;
	logic [3:0] respIdx;
	logic isErr;
	logic echoSent;
	logic [4:0] hv;
	assign hv = hexVal(rxData);
	// RULE1 link format
	ahl_uart #(.BIT_CYC(BIT_CYC)) uart (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.rxd(serialRx),
		.txd(serialTx),
		.rxValid(rxValid),
		.rxData(rxData),
		.txValid(txValid),
		.txData(txData),
		.txReady(txReady)
	);
	assign sessionBusy = (state != AHL_IDLE);
	assign serialTxEn = (state == AHL_ECHO) || (state == AHL_SEND) || !txReady;
	assign txValid = txReady && ((state == AHL_ECHO && !echoSent) ||
		(state == AHL_SEND && respIdx < respLen));
	assign txData = (state == AHL_ECHO) ? `AHL_CH_ENQ : resp[respIdx[2:0]];
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= AHL_IDLE;
			echoSent <= 1'b0;
			respIdx <= 4'h0;
		end else begin
			case (state)
				// RULE2 RULE12 idle open
				AHL_IDLE: begin
					echoSent <= 1'b0;
					if (rxValid && rxData == `AHL_CH_ENQ) begin
						state <= AHL_ECHO;
					end
				end
				// RULE3 echo control byte
				AHL_ECHO: begin
					if (txValid) begin
						echoSent <= 1'b1;
					end else if (echoSent && txReady) begin
						state <= AHL_RECV;
					end
				end
				// RULE5 RULE11 frame receipt
				AHL_RECV: begin
					if (rxValid && sawStar && rxData == `AHL_CH_CR) begin
						state <= AHL_EXEC;
					end else if (rxValid && frameLen == `AHL_FRAME_MAX) begin
						state <= AHL_IDLE;
					end
				end
				// RULE10 automatic reply
				AHL_EXEC: begin
					respIdx <= 4'h0;
					state <= AHL_SEND;
				end
				// RULE8 session end
				AHL_SEND: begin
					if (txValid) begin
						respIdx <= respIdx + 4'h1;
					end else if (respIdx == respLen && txReady) begin
						state <= AHL_IDLE;
					end
				end
				default: state <= AHL_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (!nrst || state != AHL_RECV) begin
			hdr0 <= 8'h00;
			hdr1 <= 8'h00;
			dataAcc <= 16'h0000;
			nibCnt <= 5'h00;
			badData <= 1'b0;
			sawStar <= 1'b0;
			frameLen <= 6'h00;
		end else if (rxValid) begin
			frameLen <= frameLen + 6'h01;
			sawStar <= (rxData == `AHL_CH_STAR);
			if (frameLen == 6'h00) begin
				hdr0 <= rxData;
			end else if (frameLen == 6'h01) begin
				hdr1 <= rxData;
			end else if (rxData != `AHL_CH_STAR && rxData != `AHL_CH_CR) begin
				// RULE6 hex decode
				if (hv[4] || sawStar) begin
					badData <= 1'b1;
				end else begin
					dataAcc <= {dataAcc[11:0], hv[3:0]};
					nibCnt <= nibCnt + 5'h01;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Commands: RI reads inputs, RO reads outputs (no data),
	// WO writes a channel: two hex of channel, two hex of 00 or 01.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			outputBits <= 16'h0000;
			respLen <= 4'h0;
			isErr <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				resp[i] <= 8'h00;
			end
		end else if (state == AHL_EXEC) begin
			// RULE7 echo header
			resp[0] <= hdr0;
			resp[1] <= hdr1;
			isErr <= 1'b0;
			if (hdr0 == 8'h52 && (hdr1 == 8'h49 || hdr1 == 8'h4f) &&
				!badData && nibCnt == 5'h00) begin
				// RULE6 hex encode
				resp[2] <= hexChar(hdr1 == 8'h49 ? inputBits[15:12] :
					outputBits[15:12]);
				resp[3] <= hexChar(hdr1 == 8'h49 ? inputBits[11:8] :
					outputBits[11:8]);
				resp[4] <= hexChar(hdr1 == 8'h49 ? inputBits[7:4] :
					outputBits[7:4]);
				resp[5] <= hexChar(hdr1 == 8'h49 ? inputBits[3:0] :
					outputBits[3:0]);
				resp[6] <= `AHL_CH_STAR;
				resp[7] <= `AHL_CH_CR;
				respLen <= 4'h8;
			end else if (hdr0 == 8'h57 && hdr1 == 8'h4f && !badData &&
				nibCnt == 5'h04 && dataAcc[15:8] < `AHL_CHANNELS &&
				dataAcc[7:1] == 7'h00) begin
				outputBits[dataAcc[11:8]] <= dataAcc[0];
				resp[2] <= `AHL_CH_STAR;
				resp[3] <= `AHL_CH_CR;
				respLen <= 4'h4;
			end else begin
				// RULE9 RULE12 error reply
				isErr <= 1'b1;
				resp[0] <= `AHL_ERR_H0;
				resp[1] <= `AHL_ERR_H1;
				resp[2] <= `AHL_CH_STAR;
				resp[3] <= `AHL_CH_CR;
				respLen <= 4'h4;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// RULE3 echo after open
	chk_echo_after_open: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_IDLE && rxValid && rxData == `AHL_CH_ENQ
		|=> state == AHL_ECHO && txValid && txData == `AHL_CH_ENQ)
		else $error("no echo after open byte");
	// RULE12 idle discards bytes
	chk_idle_discard: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_IDLE && rxValid && rxData != `AHL_CH_ENQ
		|=> state == AHL_IDLE)
		else $error("idle left on non-open byte");
	// RULE5 frame end
	chk_frame_end: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_RECV && rxValid && sawStar && rxData == `AHL_CH_CR
		|=> state == AHL_EXEC ##1 state == AHL_SEND)
		else $error("terminator not acted on");
	// RULE5 frame length limit
	chk_frame_limit: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_RECV && rxValid && frameLen == `AHL_FRAME_MAX &&
		!(sawStar && rxData == `AHL_CH_CR)
		|=> state == AHL_IDLE)
		else $error("overlong frame not dropped");
	// RULE7 header echoed
	chk_header_echo: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_EXEC |=> isErr ||
		(resp[0] == $past(hdr0) && resp[1] == $past(hdr1)))
		else $error("reply header differs");
	// RULE9 error header
	chk_error_header: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_EXEC && badData |=> isErr && resp[0] == `AHL_ERR_H0)
		else $error("bad data not rejected");
	// RULE8 session ends
	chk_session_end: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_SEND && respIdx == respLen && txReady && !txValid
		|=> state == AHL_IDLE)
		else $error("session did not end");
	// RULE10 reply starts
	chk_reply_start: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_EXEC ##1 txReady |-> txValid && respIdx == 4'h0)
		else $error("reply not started");
	// RULE6 write decode
	chk_write_apply: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == AHL_EXEC && hdr0 == 8'h57 && hdr1 == 8'h4f && !badData &&
		nibCnt == 5'h04 && dataAcc[15:8] < `AHL_CHANNELS &&
		dataAcc[7:1] == 7'h00
		|=> outputBits[$past(dataAcc[11:8])] == $past(dataAcc[0]))
		else $error("write not applied");
endmodule
`default_nettype wire

// [verilog/ahl_uart.sv]
// Byte-level serial receiver and transmitter, 8 data bits, 1 stop, no parity.
`timescale 1ns/1ps
`default_nettype none
`include "ahl_cfg.svh"
module ahl_uart import ahl_pkg::*; #(
	parameter int BIT_CYC = `AHL_BIT_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic rxd,
	output logic txd,
	output logic rxValid,
	output ahl_byte_t rxData,
	input wire logic txValid,
	input wire ahl_byte_t txData,
	output logic txReady
);
	if (BIT_CYC < 4 || BIT_CYC > 65535) begin : gen_bad_bit_cyc
		$error("ahl_uart: bit period out of range");
	end
	localparam logic [15:0] BC = 16'(BIT_CYC);
	localparam logic [15:0] HALF = 16'(BIT_CYC / 2);
	logic [15:0] rxCnt;
	logic [3:0] rxBit;
	logic rxBusy;
	logic [7:0] rxSh;
	logic [15:0] txCnt;
	logic [3:0] txBit;
	logic [9:0] txSh;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rxBusy <= 1'b0;
			rxCnt <= 16'h0000;
			rxBit <= 4'h0;
			rxSh <= 8'h00;
			rxValid <= 1'b0;
			rxData <= 8'h00;
		end else begin
			rxValid <= 1'b0;
			if (!rxBusy) begin
				if (!rxd) begin
					rxBusy <= 1'b1;
					rxCnt <= HALF;
					rxBit <= 4'h0;
				end
			end else if (rxCnt != 16'h0000) begin
				rxCnt <= rxCnt - 16'h0001;
			end else begin
				rxCnt <= BC - 16'h0001;
				rxBit <= rxBit + 4'h1;
				if (rxBit == 4'h0) begin
					if (rxd) begin
						rxBusy <= 1'b0;
					end
				end else if (rxBit == 4'h9) begin
					rxBusy <= 1'b0;
					if (rxd) begin
						rxValid <= 1'b1;
						rxData <= rxSh;
					end
				end else begin
					rxSh <= {rxd, rxSh[7:1]};
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	assign txReady = (txBit == 4'h0);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			txCnt <= 16'h0000;
			txBit <= 4'h0;
			txSh <= 10'h3ff;
			txd <= 1'b1;
		end else if (txBit == 4'h0) begin
			txd <= 1'b1;
			if (txValid) begin
				// An eleventh step keeps the stop bit up a full bit time.
				txSh <= {1'b1, txData, 1'b0};
				txBit <= 4'hb;
				txCnt <= 16'h0000;
			end
		end else if (txCnt != 16'h0000) begin
			txCnt <= txCnt - 16'h0001;
		end else begin
			txd <= txSh[0];
			txSh <= {1'b1, txSh[9:1]};
			txCnt <= BC - 16'h0001;
			txBit <= txBit - 4'h1;
		end
	end
endmodule
`default_nettype wire
